/* File: include/otp_prog_pkg.sv */
/*
  Constants for the one-time programmable memory programmer: pin timing
  in nanoseconds, derived cycle counts, retry limit and address width.
  Assumes a single 250 MHz system clock.
*/
package otp_prog_pkg;
  // ----------------------------------------------------------------------
  // Clock and sizes
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int MAX_RETRY = 10;
  localparam int CNT_W = 16;
  // ----------------------------------------------------------------------
  // Pin timing, as printed (ns)
  // ----------------------------------------------------------------------
  localparam int T_ALE_NS = 500;
  localparam int T_LAT_HOLD_NS = 100;
  localparam int T_LATCH_VPP_NS = 2000;
  localparam int T_VPP_SETUP_NS = 2000;
  localparam int T_VPP_HOLD_NS = 2000;
  localparam int T_VPP_RECOV_NS = 2000;
  localparam int T_VCC_SETUP_NS = 2000;
  localparam int T_DATA_VALID_NS = 150;
  localparam int T_FLOAT_NS = 130;
  localparam int T_PULSE_NOM_NS = 50000;
  localparam int T_PULSE_MIN_NS = 47500;
  localparam int T_PULSE_MAX_NS = 52500;
  // ----------------------------------------------------------------------
  // Cycle counts: least times round up, longest round down
  // ----------------------------------------------------------------------
  localparam int ALE_CYC = (T_ALE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LAT_HOLD_CYC = (T_LAT_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LATCH_VPP_CYC = (T_LATCH_VPP_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_SETUP_CYC = (T_VPP_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_HOLD_CYC = (T_VPP_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int VPP_RECOV_CYC = (T_VPP_RECOV_NS + CLK_NS - 1) / CLK_NS;
  localparam int VCC_SETUP_CYC = (T_VCC_SETUP_NS + CLK_NS - 1) / CLK_NS;
  // Extra four cycles cover the three-stage input synchroniser
  localparam int READ_CYC = (T_DATA_VALID_NS + CLK_NS - 1) / CLK_NS + 4;
  localparam int FLOAT_CYC = (T_FLOAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_NOM_CYC = T_PULSE_NOM_NS / CLK_NS;
  localparam int PULSE_MIN_CYC = (T_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_MAX_CYC = T_PULSE_MAX_NS / CLK_NS;
endpackage : otp_prog_pkg

/* File: logic/otp_program_verify_sequencer.sv */
/*
  Programmer for a 64K x 8 one-time programmable memory with multiplexed
  low address/data lines. Runs the one-pulse first pass, the verify and
  retry loop, the read-back compare, and identification reads.
  Assumes external switches turn vcc_on/vcc_prog/vpp_high into supply
  levels, and a user source memory answering src_req on the same clock.
*/
`timescale 1ns/1ns
module otp_program_verify_sequencer #(
  parameter int PULSE_CYC = otp_prog_pkg::PULSE_NOM_CYC, // Pulse length
  parameter int LAST_ADDR = 65535 // Highest address programmed
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic prog_start, // Pulse: program whole part
  input wire logic id_start, // Pulse: read identification code
  input wire logic id_sel, // 0 maker code, 1 type code
  output logic [otp_prog_pkg::ADDR_W-1:0] src_addr, // Source address
  output logic src_req, // Pulse: fetch source byte
  input wire logic [otp_prog_pkg::DATA_W-1:0] src_data, // Source byte
  input wire logic src_valid, // Source byte valid
  output logic busy, // Sequence running
  output logic done, // Pulse: sequence ended
  output logic pass, // Last programming passed
  output logic fail, // Last programming failed
  output logic [otp_prog_pkg::ADDR_W-1:0] fail_addr, // First bad address
  output logic [otp_prog_pkg::DATA_W-1:0] id_value, // Identification byte
  output logic [otp_prog_pkg::DATA_W-1:0] muxed_addr_data_lines_drv, // Out
  output logic muxed_addr_data_lines_en, // High while driving
  input wire logic [otp_prog_pkg::DATA_W-1:0] muxed_addr_data_lines_in, // In
  output logic id_select_line, // Address bit 8
  output logic [6:0] upper_addr, // Address bits 15..9
  output logic ale, // Latch strobe and program pulse
  output logic oe_n, // Output enable, logic level
  output logic vpp_high, // Program pin at high voltage
  output logic vcc_on, // Device supply present
  output logic vcc_prog // Supply at program level
);
  import otp_prog_pkg::*;

  initial begin
    if (PULSE_CYC < 1 || PULSE_CYC >= (1 << CNT_W)) begin
      $error("PULSE_CYC out of counter range");
    end
    if (LAST_ADDR < 0 || LAST_ADDR >= (1 << ADDR_W)) begin
      $error("LAST_ADDR out of address range");
    end
  end

  typedef enum logic [4:0] {
    ST_IDLE, ST_PWR, ST_LATCH, ST_LHOLD, ST_FETCH, ST_WAITSRC, ST_SETUP,
    ST_VPP_UP, ST_PULSE, ST_VHOLD, ST_VPP_DN, ST_READ, ST_CHECK, ST_FLOAT,
    ST_LOWER, ST_END
  } state_type;
  typedef enum logic [1:0] {
    PH_FIRST, PH_LOOP, PH_READBACK, PH_ID
  } phase_type;

  logic [1:0] rst_pipe_q;
  logic rst_n;
  state_type state_q;
  phase_type phase_q;
  logic [CNT_W-1:0] wait_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic [3:0] retry_q;
  logic bad_q;
  logic [DATA_W-1:0] s1_q, s2_q, s3_q, rd_q;
  logic last_addr;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // Two flops so release never lands near a clock edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe_q <= 2'h0;
    end else begin
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe_q[1];

  // ----------------------------------------------------------------------
  // Data line input synchroniser
  // ----------------------------------------------------------------------
  // Accept a new value only once stages two and three agree
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      rd_q <= 8'h00;
    end else begin
      s1_q <= muxed_addr_data_lines_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        rd_q <= s3_q;
      end
    end
  end

  assign last_addr = (addr_q == ADDR_W'(LAST_ADDR));
  assign src_addr = addr_q;
  assign id_select_line = addr_q[8];
  assign upper_addr = addr_q[15:9];

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Each timed state loads wait_q with its count less one on entry
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      phase_q <= PH_FIRST;
      wait_q <= 16'h0000;
      addr_q <= 16'h0000;
      data_q <= 8'h00;
      retry_q <= 4'h0;
      bad_q <= 1'b0;
      src_req <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      fail <= 1'b0;
      fail_addr <= 16'h0000;
      id_value <= 8'h00;
      muxed_addr_data_lines_drv <= 8'h00;
      muxed_addr_data_lines_en <= 1'b0;
      ale <= 1'b0;
      oe_n <= 1'b1;
      vpp_high <= 1'b0;
      vcc_on <= 1'b0;
      vcc_prog <= 1'b0;
    end else begin
      src_req <= 1'b0;
      done <= 1'b0;
      if (wait_q != 16'h0000) begin
        wait_q <= wait_q - 16'h0001;
      end
      unique case (state_q)
        ST_IDLE: begin
          if (prog_start) begin
            addr_q <= 16'h0000;
            phase_q <= PH_FIRST;
            bad_q <= 1'b0;
            pass <= 1'b0;
            fail <= 1'b0;
            busy <= 1'b1;
            vcc_on <= 1'b1;
            vcc_prog <= 1'b1;
            wait_q <= CNT_W'(VCC_SETUP_CYC - 1);
            state_q <= ST_PWR;
          end else if (id_start) begin
            addr_q <= {7'h00, id_sel, 8'h00};
            phase_q <= PH_ID;
            busy <= 1'b1;
            vcc_on <= 1'b1;
            wait_q <= CNT_W'(VCC_SETUP_CYC - 1);
            state_q <= ST_PWR;
          end
        end
        // Supply settles before anything else moves
        ST_PWR: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_LATCH;
            wait_q <= CNT_W'(ALE_CYC - 1);
          end
        end
        // Low address driven while the strobe is high
        ST_LATCH: begin
          muxed_addr_data_lines_drv <= addr_q[7:0];
          muxed_addr_data_lines_en <= 1'b1;
          ale <= 1'b1;
          // Count restarts at the strobe rise so the width is full
          if (!ale) begin
            wait_q <= CNT_W'(ALE_CYC - 1);
          end else if (wait_q == 16'h0000) begin
            ale <= 1'b0;
            state_q <= ST_LHOLD;
            wait_q <= CNT_W'(LAT_HOLD_CYC - 1);
          end
        end
        ST_LHOLD: begin
          if (wait_q == 16'h0000) begin
            muxed_addr_data_lines_en <= 1'b0;
            if (phase_q == PH_ID) begin
              oe_n <= 1'b0;
              wait_q <= CNT_W'(READ_CYC - 1);
              state_q <= ST_READ;
            end else begin
              state_q <= ST_FETCH;
            end
          end
        end
        // Source byte is fetched afresh after each address latch except in code reads; loop retries reuse data_q
        ST_FETCH: begin
          src_req <= 1'b1;
          state_q <= ST_WAITSRC;
        end
        ST_WAITSRC: begin
          if (src_valid) begin
            data_q <= src_data;
            if (phase_q != PH_FIRST) begin
              // Loop and read-back both look before any pulse
              oe_n <= 1'b0;
              wait_q <= CNT_W'(READ_CYC - 1);
              state_q <= ST_READ;
            end else begin
              state_q <= ST_SETUP;
              wait_q <= CNT_W'(LATCH_VPP_CYC - 1);
            end
          end
        end
        // Data on the lines; program pin waits after the strobe fell
        ST_SETUP: begin
          muxed_addr_data_lines_drv <= data_q;
          muxed_addr_data_lines_en <= 1'b1;
          if (wait_q == 16'h0000) begin
            vpp_high <= 1'b1;
            wait_q <= CNT_W'(VPP_SETUP_CYC - 1);
            state_q <= ST_VPP_UP;
          end
        end
        ST_VPP_UP: begin
          if (wait_q == 16'h0000) begin
            ale <= 1'b1;
            wait_q <= CNT_W'(PULSE_CYC - 1);
            state_q <= ST_PULSE;
          end
        end
        // Exactly PULSE_CYC cycles of strobe high
        ST_PULSE: begin
          if (wait_q == 16'h0000) begin
            ale <= 1'b0;
            wait_q <= CNT_W'(VPP_HOLD_CYC - 1);
            state_q <= ST_VHOLD;
          end
        end
        ST_VHOLD: begin
          if (wait_q == 16'h0000) begin
            vpp_high <= 1'b0;
            muxed_addr_data_lines_en <= 1'b0;
            wait_q <= CNT_W'(VPP_RECOV_CYC - 1);
            state_q <= ST_VPP_DN;
          end
        end
        ST_VPP_DN: begin
          if (wait_q == 16'h0000) begin
            if (phase_q == PH_FIRST) begin
              // No verify between first-pass pulses
              if (last_addr) begin
                phase_q <= PH_LOOP;
                addr_q <= 16'h0000;
                retry_q <= 4'h0;
              end else begin
                addr_q <= addr_q + 16'h0001;
              end
              wait_q <= CNT_W'(ALE_CYC - 1);
              state_q <= ST_LATCH;
            end else begin
              oe_n <= 1'b0;
              wait_q <= CNT_W'(READ_CYC - 1);
              state_q <= ST_READ;
            end
          end
        end
        // Loop entry for a fresh address verifies before any pulse
        ST_READ: begin
          if (wait_q == 16'h0000) begin
            oe_n <= 1'b1;
            state_q <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          wait_q <= CNT_W'(FLOAT_CYC - 1);
          state_q <= ST_FLOAT;
          if (phase_q == PH_ID) begin
            id_value <= rd_q;
          end else if (phase_q == PH_READBACK && rd_q != data_q) begin
            if (!bad_q) begin
              fail_addr <= addr_q;
            end
            bad_q <= 1'b1;
          end else if (phase_q == PH_LOOP && rd_q != data_q) begin
            if (retry_q == 4'(MAX_RETRY)) begin
              bad_q <= 1'b1;
              fail_addr <= addr_q;
            end
          end
        end
        ST_FLOAT: begin
          if (wait_q == 16'h0000) begin
            if (phase_q == PH_ID) begin
              state_q <= ST_END;
            end else if (phase_q == PH_LOOP && bad_q) begin
              // Stop at once; program pin already at logic level
              vcc_prog <= 1'b0;
              wait_q <= CNT_W'(VCC_SETUP_CYC - 1);
              state_q <= ST_LOWER;
            end else if (phase_q == PH_LOOP && rd_q != data_q) begin
              retry_q <= retry_q + 4'h1;
              wait_q <= CNT_W'(LATCH_VPP_CYC - 1);
              state_q <= ST_SETUP;
            end else if (last_addr && phase_q == PH_LOOP) begin
              vcc_prog <= 1'b0;
              wait_q <= CNT_W'(VCC_SETUP_CYC - 1);
              state_q <= ST_LOWER;
            end else if (last_addr) begin
              state_q <= ST_END;
            end else begin
              addr_q <= addr_q + 16'h0001;
              retry_q <= 4'h0;
              wait_q <= CNT_W'(ALE_CYC - 1);
              state_q <= ST_LATCH;
            end
          end
        end
        // Supply back to read level before read-back
        ST_LOWER: begin
          if (wait_q == 16'h0000) begin
            if (bad_q) begin
              state_q <= ST_END;
            end else begin
              phase_q <= PH_READBACK;
              addr_q <= 16'h0000;
              wait_q <= CNT_W'(ALE_CYC - 1);
              state_q <= ST_LATCH;
            end
          end
        end
        // Supply removed last, after the program pin is low
        ST_END: begin
          vcc_on <= 1'b0;
          vcc_prog <= 1'b0;
          busy <= 1'b0;
          done <= 1'b1;
          if (phase_q != PH_ID) begin
            pass <= !bad_q;
            fail <= bad_q;
          end
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule : otp_program_verify_sequencer

/* File: test/otp_seq_sva.sv */
/*
  Checker for the sequencer pins: pulse width, supply order, latch to
  program pin spacing, first address, bus turnaround and stop on fail.
  Assumes it is bound to the sequencer and sees only its ports.
*/
`timescale 1ns/1ns
module otp_seq_sva
  import otp_prog_pkg::*;
#(
  parameter int PULSE_CYC = 20 // Program pulse length
) (
  input wire logic mclk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic busy, // Sequence running
  input wire logic fail, // Part failed
  input wire logic [DATA_W-1:0] muxed_addr_data_lines_drv, // Lines out
  input wire logic muxed_addr_data_lines_en, // Lines driven
  input wire logic id_select_line, // Address bit 8
  input wire logic [6:0] upper_addr, // Address bits 15..9
  input wire logic ale, // Latch strobe
  input wire logic oe_n, // Output enable
  input wire logic vpp_high, // Program pin raised
  input wire logic vcc_on, // Supply present
  input wire logic vcc_prog // Supply at program level
);
  // ----------------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] pcnt_q;
  logic [10:0] lcnt_q;
  logic first_q;

  // Cycles of the running program pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) pcnt_q <= '0;
    else if (ale && vpp_high) pcnt_q <= pcnt_q + 1'b1;
    else pcnt_q <= '0;
  end

  // Cycles since strobe fell, saturating so it never wraps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) lcnt_q <= '0;
    else if (ale) lcnt_q <= '0;
    else if (lcnt_q != '1) lcnt_q <= lcnt_q + 1'b1;
  end

  // Armed by the supply rise, spent on the first latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) first_q <= 1'b0;
    else if ($rose(vcc_prog)) first_q <= 1'b1;
    else if (ale) first_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence first_latch_s;
    first_q && $rose(ale);
  endsequence

  sequence zero_addr_s;
    muxed_addr_data_lines_en && muxed_addr_data_lines_drv == 8'h00
      && upper_addr == 7'h00 && !id_select_line;
  endsequence

  pulse_width_a: assert property (
    $fell(ale) && vpp_high |-> pcnt_q == PULSE_CYC)
    else $error("program pulse length wrong");
  pulse_ceiling_a: assert property (
    ale && vpp_high |-> pcnt_q < PULSE_CYC)
    else $error("program pulse too long");
  supply_first_a: assert property (
    vpp_high |-> vcc_on && vcc_prog)
    else $error("program pin raised without supply");
  latch_gap_a: assert property (
    $rose(vpp_high) |-> lcnt_q >= LATCH_VPP_CYC)
    else $error("program pin raised too soon after strobe");
  first_addr_a: assert property (
    first_latch_s |-> zero_addr_s)
    else $error("first latched address not zero");
  bus_turn_a: assert property (
    !oe_n |-> !muxed_addr_data_lines_en)
    else $error("lines driven while device outputs");
  readback_level_a: assert property (
    vcc_on && !vcc_prog |-> !vpp_high)
    else $error("program pin high at read supply");
  fail_stop_a: assert property (
    fail && !busy |-> !vpp_high && !vcc_on)
    else $error("supplies left on after failure");
endmodule : otp_seq_sva

bind otp_program_verify_sequencer otp_seq_sva #(.PULSE_CYC(PULSE_CYC)) chk (
  .mclk(mclk), .arst_n(arst_n), .busy(busy), .fail(fail),
  .muxed_addr_data_lines_drv(muxed_addr_data_lines_drv),
  .muxed_addr_data_lines_en(muxed_addr_data_lines_en),
  .id_select_line(id_select_line), .upper_addr(upper_addr), .ale(ale),
  .oe_n(oe_n), .vpp_high(vpp_high), .vcc_on(vcc_on), .vcc_prog(vcc_prog)
);

/* File: test/otp_device_model.sv */
/*
  Behavioural one-time programmable memory: latches the low address on
  the strobe fall, programs on pulses, answers reads and code reads.
  Assumes the bench resolves the shared lines and drives id_mode.
*/
`timescale 1ns/1ns
module otp_device_model #(
  parameter logic [7:0] MAKER_CODE = 8'h6B, // Arbitrary value
  parameter logic [7:0] TYPE_CODE = 8'hD2 // Arbitrary value
) (
  input wire logic ale, // Latch strobe
  input wire logic oe_n, // Output enable
  input wire logic vpp_high, // Program pin raised
  input wire logic vcc_on, // Supply present
  input wire logic vcc_prog, // Supply at program level
  input wire logic id_select_line, // Address bit 8
  input wire logic [6:0] upper_addr, // Address bits 15..9
  input wire logic [7:0] lines, // Resolved shared lines
  input wire logic id_mode, // Code read selected
  input wire logic blank, // Rise: fresh part
  input wire logic [15:0] hard_addr, // Slow to program
  input wire logic [7:0] hard_pulses, // Pulses it needs
  output logic [7:0] dev_out, // Device output byte
  output logic dev_en // Device drives lines
);
  logic [7:0] mem [0:65535];
  logic [7:0] low_q = 8'h00;
  logic [7:0] hits_q = 8'h00;
  wire [15:0] addr = {upper_addr, id_select_line, low_q};

  // Fresh part reads all ones
  always @(posedge blank) begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
    hits_q = 8'h00;
  end

  // Strobe fall latches address, or ends a pulse; cells only clear bits
  always @(negedge ale) begin
    if (!vpp_high) low_q = lines;
    else if (vcc_on && vcc_prog) begin
      if (addr == hard_addr) hits_q = hits_q + 8'h01;
      if (addr != hard_addr || hits_q >= hard_pulses)
        mem[addr] = mem[addr] & lines;
    end
  end

  // Output only at logic level pins
  assign dev_en = vcc_on && !oe_n && !vpp_high && !ale;
  assign dev_out = !id_mode ? mem[addr] :
    (id_select_line ? TYPE_CODE : MAKER_CODE);
endmodule : otp_device_model

/* File: test/otp_program_verify_sequencer_test.sv */
/*
  Self-checking bench: code reads, programming with retries, and a
  part that never verifies. Assumes the device model beside it.
*/
`timescale 1ns/1ns
module otp_program_verify_sequencer_test;
  import otp_prog_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int PULSE = 20;
  localparam int LAST = 3;
  localparam int LIMIT = 60000;
  localparam logic [7:0] MAKER = 8'h6B; // Arbitrary value
  localparam logic [7:0] TYPE = 8'hD2; // Arbitrary value
  logic mclk = 0, arst_n = 0, prog_start = 0, id_start = 0, id_sel = 0;
  logic src_valid = 0, id_mode = 0, blank = 0, ale_p = 0, oe_p = 1;
  logic [7:0] src_data = 0, hard_pulses = 1, last_q = 0;
  logic [15:0] hard_addr = 16'hFFFF;
  logic [ADDR_W-1:0] src_addr, fail_addr;
  logic [7:0] id_value, drv, dev_out, lines;
  logic src_req, busy, done, pass, fail, en, dev_en, id_select_line;
  logic ale, oe_n, vpp_high, vcc_on, vcc_prog;
  logic [6:0] upper_addr;
  int fail_count = 0, compares = 0, sw = 0;
  int pulses, verifies, reads, early;

  // Released lines show a changing pattern, never a held value
  assign lines = en ? drv : dev_en ? dev_out : ~last_q;
  always #2 mclk = ~mclk;

  otp_program_verify_sequencer #(.PULSE_CYC(PULSE), .LAST_ADDR(LAST)) dut (
    .mclk(mclk), .arst_n(arst_n), .prog_start(prog_start),
    .id_start(id_start), .id_sel(id_sel), .src_addr(src_addr),
    .src_req(src_req), .src_data(src_data), .src_valid(src_valid),
    .busy(busy), .done(done), .pass(pass), .fail(fail),
    .fail_addr(fail_addr), .id_value(id_value),
    .muxed_addr_data_lines_drv(drv), .muxed_addr_data_lines_en(en),
    .muxed_addr_data_lines_in(lines), .id_select_line(id_select_line),
    .upper_addr(upper_addr), .ale(ale), .oe_n(oe_n), .vpp_high(vpp_high),
    .vcc_on(vcc_on), .vcc_prog(vcc_prog));

  otp_device_model #(.MAKER_CODE(MAKER), .TYPE_CODE(TYPE)) dev (
    .ale(ale), .oe_n(oe_n), .vpp_high(vpp_high), .vcc_on(vcc_on),
    .vcc_prog(vcc_prog), .id_select_line(id_select_line),
    .upper_addr(upper_addr), .lines(lines), .id_mode(id_mode),
    .blank(blank), .hard_addr(hard_addr), .hard_pulses(hard_pulses),
    .dev_out(dev_out), .dev_en(dev_en));

  // Count pulses, verifies and read-backs seen on the pins
  always @(posedge mclk) begin
    if (ale && !ale_p && vpp_high) pulses++;
    if (!oe_n && oe_p && busy && vcc_prog) verifies++;
    if (!oe_n && oe_p && busy && !vcc_prog) reads++;
    if (!oe_n && oe_p && vcc_prog && pulses <= LAST) early++;
    ale_p = ale;
    oe_p = oe_n;
    last_q <= lines;
  end

  // Source memory answers three cycles late; data churns when not valid
  always @(negedge mclk) begin
    src_valid = (sw == 1);
    src_data = (sw == 1) ? data_for(src_addr) : ~src_data;
    if (src_req) sw = 3;
    else if (sw > 0) sw--;
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  function automatic logic [7:0] data_for(input logic [15:0] a);
    return 8'h3C ^ a[7:0];
  endfunction : data_for

  task check(input logic [15:0] seen, input logic [15:0] exp,
             input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check

  task end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  task wait_done;
    int i;
    for (i = 0; i < LIMIT; i++) begin
      @(posedge mclk);
      #1;
      if (done === 1'b1) break;
    end
    if (i == LIMIT) begin
      fail_count++;
      $display("unexpected at %0t: no done", $time);
      end_of_test;
    end
  endtask : wait_done

  task run_prog(input logic [15:0] ha, input logic [7:0] hp);
    @(negedge mclk);
    hard_addr = ha;
    hard_pulses = hp;
    blank = 1'b1;
    pulses = 0;
    verifies = 0;
    reads = 0;
    early = 0;
    @(negedge mclk);
    blank = 1'b0;
    prog_start = 1'b1;
    @(negedge mclk);
    prog_start = 1'b0;
    wait_done;
    @(negedge mclk);
  endtask : run_prog

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task t_reset;
    check({oe_n, busy, ale, vpp_high, vcc_on, en, vcc_prog, done, src_req,
           pass, fail}, 16'h400, "reset pins");
    check({drv, id_value}, 16'h0000, "reset bytes");
    check(src_addr | fail_addr | {upper_addr, id_select_line, 8'h00},
          16'h0000, "reset address");
    $display("test reset done");
  endtask : t_reset

  task t_id;
    for (int s = 0; s < 2; s++) begin
      @(negedge mclk);
      id_mode = 1'b1;
      id_sel = s[0];
      id_start = 1'b1;
      @(negedge mclk);
      id_start = 1'b0;
      wait_done;
      check(id_value, s ? TYPE : MAKER, "code read");
      @(negedge mclk);
      id_mode = 1'b0;
    end
    $display("test id done");
  endtask : t_id

  task t_retry;
    run_prog(16'd2, 8'd11);
    check(pass, 1, "pass after retries");
    check(fail, 0, "fail after retries");
    check(16'(pulses), LAST + 11, "pulse count");
    check(16'(early), 0, "verify in first pass");
    check(16'(verifies), LAST + 11, "verify count");
    check(16'(reads), LAST + 1, "read-back count");
    for (int a = 0; a <= LAST; a++)
      check(dev.mem[a], data_for(a), "stored byte");
    $display("test retry done");
  endtask : t_retry

  task t_fail;
    run_prog(16'd1, 8'd12);
    check(fail, 1, "part not failed");
    check(pass, 0, "pass on failed part");
    check(fail_addr, 1, "failing address");
    check(16'(pulses), LAST + 11, "pulses after failure");
    check(16'(verifies), 12, "verify count");
    check(16'(reads), 0, "read-back after failure");
    $display("test fail done");
  endtask : t_fail

  // Reset three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset;
    t_id;
    t_retry;
    t_fail;
    end_of_test;
  end
endmodule : otp_program_verify_sequencer_test
